//--- rtl/mas_alu_top.sv
// alu subset top: axi4-lite register slave, file registers, accumulator, flags, direction registers
// assumes one clock aclk, synchronous active-low aresetn, a master keeping one write and one read open
//
// Summary of operation
// - subtract with borrow: file minus accumulator minus inverted carry, destination bit chooses target
// - subtract with borrow updates carry, nibble carry and zero from its result
// - two's complement subtraction; borrow in is complement of carry, cleared carry subtracts one
// - nibble exchange swaps file nibbles, writes by destination bit, leaves flags alone
// - xor immediate xors accumulator with literal into accumulator, updates only zero
// - port direction load copies accumulator to direction register 5, 6 or 7; flags unchanged
// - xor file register xors accumulator with file, writes by destination bit, updates only zero
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module mas_alu_top
    import mas_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [`MAS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [`MAS_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [`MAS_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [`MAS_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // port direction registers
    output mas_byte_t port_a_direction,
    output mas_byte_t port_b_direction,
    output mas_byte_t port_c_direction
);

    // bus side state
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [`MAS_DATA_W-1:0] rdata_ff;
    logic [`MAS_ADDR_W-1:0] awaddr_ff;
    logic [`MAS_DATA_W-1:0] wdata_ff;
    logic [3:0] wstrb_ff;

    // core state
    mas_byte_t file_mem_ff [`MAS_FILE_DEPTH];
    mas_byte_t acc_ff;
    logic [`MAS_ST_W-1:0] status_ff;
    mas_byte_t dir_a_ff;
    mas_byte_t dir_b_ff;
    mas_byte_t dir_c_ff;
    mas_byte_t result_ff;
    logic [`MAS_INSTR_W-1:0] instr_ff;
    logic exec_ff;

    // write decode
    logic wr_fire;
    logic wr_is_file;
    logic [6:0] wr_idx;
    logic wr_hit;
    logic [`MAS_DATA_W-1:0] wmask;
    logic [`MAS_DATA_W-1:0] instr_merge;

    // execution signals
    mas_opcode_t op;
    logic dest_file;
    logic [6:0] faddr;
    mas_byte_t lit;
    mas_byte_t file_val;
    mas_byte_t sub_res;
    logic sub_c;
    logic sub_dc;
    logic sub_z;
    mas_byte_t xor_res;
    mas_byte_t swap_res;
    logic xor_z;
    mas_byte_t nxt_result;
    logic res_valid;
    logic res_to_file;
    logic upd_c_dc;
    logic upd_z;
    logic nxt_z;
    logic load_a;
    logic load_b;
    logic load_c;

    // read decode
    logic [`MAS_DATA_W-1:0] nxt_rdata;
    logic [1:0] nxt_rresp;

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign port_a_direction = dir_a_ff;
    assign port_b_direction = dir_b_ff;
    assign port_c_direction = dir_c_ff;

    // both address and data held, response not yet raised
    assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
    assign wr_is_file = (awaddr_ff[`MAS_FILE_SEL_MSB:`MAS_FILE_SEL_LSB] == `MAS_FILE_SEL);
    assign wr_idx = awaddr_ff[`MAS_FILE_IDX_MSB:`MAS_ADDR_LSB];

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_strb
            assign wmask[gb*8 +: 8] = {8{wstrb_ff[gb]}};
        end
    endgenerate

    assign instr_merge = ({8'h00, instr_ff} & ~wmask) | (wdata_ff & wmask);

    always_comb begin
        wr_hit = wr_is_file;
        unique case (awaddr_ff)
            `MAS_OFF_INSTR, `MAS_OFF_ACC, `MAS_OFF_STATUS,
            `MAS_OFF_DIR_A, `MAS_OFF_DIR_B, `MAS_OFF_DIR_C: wr_hit = 1'b1;
            default: ;
        endcase
    end

    // write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            awaddr_ff <= '0;
        end else if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            awaddr_ff <= s_axi_awaddr;
        end else if (bvalid_ff && s_axi_bready) begin
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff <= 1'b1;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (bvalid_ff && s_axi_bready) begin
            wready_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `MAS_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? `MAS_RESP_OKAY : `MAS_RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // instruction word; a write launches one execution next cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_ff <= `MAS_RST_INSTR;
            exec_ff <= 1'b0;
        end else begin
            exec_ff <= wr_fire && (awaddr_ff == `MAS_OFF_INSTR);
            if (wr_fire && (awaddr_ff == `MAS_OFF_INSTR)) begin
                instr_ff <= instr_merge[`MAS_INSTR_W-1:0];
            end
        end
    end

    // operand fields and datapath units
    assign op = mas_opcode_t'(instr_ff[`MAS_OP_MSB:`MAS_OP_LSB]);
    assign dest_file = (instr_ff[`MAS_DEST_BIT] != `MAS_DEST_ACC);
    assign faddr = instr_ff[`MAS_FADDR_MSB:`MAS_FADDR_LSB];
    assign lit = instr_ff[`MAS_LIT_MSB:`MAS_LIT_LSB];
    assign file_val = file_mem_ff[faddr];

    mas_sub_unit u_sub (
        .file_val(file_val),
        .acc_val(acc_ff),
        .carry_in(status_ff[`MAS_ST_C]),
        .result(sub_res),
        .carry_out(sub_c),
        .nibble_carry_out(sub_dc),
        .zero_out(sub_z)
    );

    mas_logic_unit u_logic (
        .acc_val(acc_ff),
        .operand((op == MAS_OP_XOR_IMMEDIATE) ? lit : file_val),
        .file_val(file_val),
        .xor_result(xor_res),
        .swap_result(swap_res),
        .xor_zero(xor_z)
    );

    // per-instruction result routing and flag selection
    always_comb begin
        nxt_result = `MAS_RST_BYTE;
        res_valid = 1'b0;
        res_to_file = 1'b0;
        upd_c_dc = 1'b0;
        upd_z = 1'b0;
        nxt_z = 1'b0;
        load_a = 1'b0;
        load_b = 1'b0;
        load_c = 1'b0;
        unique case (op)
            MAS_OP_SUBTRACT_WITH_BORROW: begin
                nxt_result = sub_res;
                res_valid = 1'b1;
                res_to_file = dest_file;
                upd_c_dc = 1'b1;
                upd_z = 1'b1;
                nxt_z = sub_z;
            end
            MAS_OP_NIBBLE_EXCHANGE: begin
                nxt_result = swap_res;
                res_valid = 1'b1;
                res_to_file = dest_file;
            end
            MAS_OP_XOR_IMMEDIATE: begin
                nxt_result = xor_res;
                res_valid = 1'b1;
                upd_z = 1'b1;
                nxt_z = xor_z;
            end
            MAS_OP_XOR_FILE_REG: begin
                nxt_result = xor_res;
                res_valid = 1'b1;
                res_to_file = dest_file;
                upd_z = 1'b1;
                nxt_z = xor_z;
            end
            MAS_OP_PORT_DIRECTION_LOAD: begin
                load_a = (faddr == `MAS_DIR_SEL_A);
                load_b = (faddr == `MAS_DIR_SEL_B);
                load_c = (faddr == `MAS_DIR_SEL_C);
            end
            default: ;
        endcase
    end

    // file registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < `MAS_FILE_DEPTH; i++) begin
                file_mem_ff[i] <= `MAS_RST_BYTE;
            end
        end else if (exec_ff && res_valid && res_to_file) begin
            file_mem_ff[faddr] <= nxt_result;
        end else if (wr_fire && wr_is_file && wstrb_ff[0]) begin
            file_mem_ff[wr_idx] <= wdata_ff[7:0];
        end
    end

    // accumulator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_ff <= `MAS_RST_BYTE;
        end else if (exec_ff && res_valid && !res_to_file) begin
            acc_ff <= nxt_result;
        end else if (wr_fire && (awaddr_ff == `MAS_OFF_ACC) && wstrb_ff[0]) begin
            acc_ff <= wdata_ff[7:0];
        end
    end

    // flags; execution wins over a software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= `MAS_RST_STATUS;
        end else if (exec_ff && (upd_c_dc || upd_z)) begin
            if (upd_c_dc) begin
                status_ff[`MAS_ST_C] <= sub_c;
                status_ff[`MAS_ST_DC] <= sub_dc;
            end
            status_ff[`MAS_ST_Z] <= nxt_z;
        end else if (wr_fire && (awaddr_ff == `MAS_OFF_STATUS) && wstrb_ff[0]) begin
            status_ff <= wdata_ff[`MAS_ST_W-1:0];
        end
    end

    // direction registers, loaded only from the accumulator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_a_ff <= `MAS_RST_DIR;
            dir_b_ff <= `MAS_RST_DIR;
            dir_c_ff <= `MAS_RST_DIR;
        end else if (exec_ff) begin
            if (load_a) dir_a_ff <= acc_ff;
            if (load_b) dir_b_ff <= acc_ff;
            if (load_c) dir_c_ff <= acc_ff;
        end
    end

    // last computed result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_ff <= `MAS_RST_BYTE;
        end else if (exec_ff && res_valid) begin
            result_ff <= nxt_result;
        end
    end

    // read decode
    always_comb begin
        nxt_rdata = '0;
        nxt_rresp = `MAS_RESP_OKAY;
        if (s_axi_araddr[`MAS_FILE_SEL_MSB:`MAS_FILE_SEL_LSB] == `MAS_FILE_SEL) begin
            nxt_rdata = {24'h000000, file_mem_ff[s_axi_araddr[`MAS_FILE_IDX_MSB:`MAS_ADDR_LSB]]};
        end else begin
            unique case (s_axi_araddr)
                `MAS_OFF_INSTR: nxt_rdata = {8'h00, instr_ff};
                `MAS_OFF_ACC: nxt_rdata = {24'h000000, acc_ff};
                `MAS_OFF_STATUS: nxt_rdata = {29'h00000000, status_ff};
                `MAS_OFF_DIR_A: nxt_rdata = {24'h000000, dir_a_ff};
                `MAS_OFF_DIR_B: nxt_rdata = {24'h000000, dir_b_ff};
                `MAS_OFF_DIR_C: nxt_rdata = {24'h000000, dir_c_ff};
                `MAS_OFF_RESULT: nxt_rdata = {24'h000000, result_ff};
                default: nxt_rresp = `MAS_RESP_SLVERR;
            endcase
        end
    end

    // read channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= `MAS_RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

endmodule : mas_alu_top

//--- rtl/mas_regs.svh
// register offsets, field positions, reset values and constants of the alu subset
// included by the package, the property checker and the bench; definitions only
`ifndef MAS_REGS_SVH
`define MAS_REGS_SVH

`define MAS_ADDR_W 12
`define MAS_DATA_W 32
`define MAS_ADDR_LSB 2

`define MAS_OFF_INSTR 12'h000
`define MAS_OFF_ACC 12'h004
`define MAS_OFF_STATUS 12'h008
`define MAS_OFF_DIR_A 12'h00C
`define MAS_OFF_DIR_B 12'h010
`define MAS_OFF_DIR_C 12'h014
`define MAS_OFF_RESULT 12'h018
`define MAS_FILE_SEL_MSB 11
`define MAS_FILE_SEL_LSB 9
`define MAS_FILE_SEL 3'h1
`define MAS_FILE_IDX_MSB 8

`define MAS_INSTR_W 24
`define MAS_OP_MSB 2
`define MAS_OP_LSB 0
`define MAS_DEST_BIT 3
`define MAS_FADDR_MSB 10
`define MAS_FADDR_LSB 4
`define MAS_LIT_MSB 23
`define MAS_LIT_LSB 16

`define MAS_ST_C 0
`define MAS_ST_DC 1
`define MAS_ST_Z 2
`define MAS_ST_W 3

`define MAS_DEST_ACC 1'b0
`define MAS_DIR_SEL_A 7'h05
`define MAS_DIR_SEL_B 7'h06
`define MAS_DIR_SEL_C 7'h07

`define MAS_RST_BYTE 8'h00
`define MAS_RST_DIR 8'hFF
`define MAS_RST_INSTR 24'h000000
`define MAS_RST_STATUS 3'h0
`define MAS_FILE_DEPTH 128

`define MAS_RESP_OKAY 2'h0
`define MAS_RESP_SLVERR 2'h2

`endif

//--- rtl/mas_pkg.sv
// types shared by the alu subset modules
// assumes mas_regs.svh is on the include path
`include "mas_regs.svh"

package mas_pkg;

    typedef logic [7:0] mas_byte_t;

    typedef enum logic [2:0] {
        MAS_OP_NONE = 3'h0,
        MAS_OP_SUBTRACT_WITH_BORROW = 3'h1,
        MAS_OP_NIBBLE_EXCHANGE = 3'h2,
        MAS_OP_XOR_IMMEDIATE = 3'h3,
        MAS_OP_XOR_FILE_REG = 3'h4,
        MAS_OP_PORT_DIRECTION_LOAD = 3'h5
    } mas_opcode_t;

endpackage : mas_pkg

//--- rtl/mas_sub_unit.sv
// subtract with borrow datapath: result and carry, nibble carry, zero flags
// purely combinational; the caller registers the outputs
`timescale 1ns/1ps

module mas_sub_unit
    import mas_pkg::*;
(
    // operands
    input wire mas_byte_t file_val,
    input wire mas_byte_t acc_val,
    input wire logic carry_in,
    // results
    output mas_byte_t result,
    output logic carry_out,
    output logic nibble_carry_out,
    output logic zero_out
);

    logic [8:0] full_sum;
    logic [4:0] low_sum;

    // f - w - !c done as f + ~w + c
    assign full_sum = {1'b0, file_val} + {1'b0, ~acc_val} + {8'h00, carry_in};
    assign low_sum = {1'b0, file_val[3:0]} + {1'b0, ~acc_val[3:0]} + {4'h0, carry_in};
    assign result = full_sum[7:0];
    assign carry_out = full_sum[8];
    assign nibble_carry_out = low_sum[4];
    assign zero_out = (full_sum[7:0] == `MAS_RST_BYTE);

endmodule : mas_sub_unit

//--- rtl/mas_logic_unit.sv
// xor and nibble exchange datapath with zero detect of the xor result
// purely combinational; the caller registers the outputs
`timescale 1ns/1ps

module mas_logic_unit
    import mas_pkg::*;
(
    // operands
    input wire mas_byte_t acc_val,
    input wire mas_byte_t operand,
    input wire mas_byte_t file_val,
    // results
    output mas_byte_t xor_result,
    output mas_byte_t swap_result,
    output logic xor_zero
);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bit
            assign xor_result[gi] = acc_val[gi] ^ operand[gi];
            assign swap_result[gi] = file_val[(gi + 4) % 8];
        end
    endgenerate

    assign xor_zero = (xor_result == `MAS_RST_BYTE);

endmodule : mas_logic_unit

//--- testbench/mas_alu_properties.sv
// port assertions for the alu subset top
// bound to mas_alu_top; one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "mas_regs.svh"

module mas_alu_properties
    import mas_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [`MAS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [`MAS_DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // direction registers
    input wire mas_byte_t port_a_direction,
    input wire mas_byte_t port_b_direction,
    input wire mas_byte_t port_c_direction
);
    logic [`MAS_ADDR_W-1:0] rd_addr_ff;
    logic rd_dir;
    logic rd_byte;
    mas_byte_t dir_sel;

    // address of the read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr_ff <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_ff <= s_axi_araddr;
        end
    end

    assign rd_dir = rd_addr_ff inside {`MAS_OFF_DIR_A, `MAS_OFF_DIR_B, `MAS_OFF_DIR_C};
    assign rd_byte = rd_dir || rd_addr_ff inside {`MAS_OFF_ACC, `MAS_OFF_RESULT} || rd_addr_ff[11:9] == 3'h1;
    assign dir_sel = (rd_addr_ff == `MAS_OFF_DIR_A) ? port_a_direction :
                     (rd_addr_ff == `MAS_OFF_DIR_B) ? port_b_direction : port_c_direction;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_dir_after_exec: assert property ($changed({port_a_direction, port_b_direction, port_c_direction}) |->
        $past(s_axi_bvalid)) else $error("direction changed with no instruction write");
    a_dir_one_port: assert property ($changed(port_a_direction) |->
        $stable(port_b_direction) && $stable(port_c_direction)) else $error("two directions changed");
    a_dir_readback: assert property (s_axi_rvalid && rd_dir |-> s_axi_rdata == {24'h000000, dir_sel})
        else $error("direction read differs from port");
    a_byte_upper_zero: assert property (s_axi_rvalid && rd_byte |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("byte register read has upper bits set");
    a_status_width: assert property (s_axi_rvalid && rd_addr_ff == `MAS_OFF_STATUS |->
        s_axi_rdata[31:3] == 29'h00000000) else $error("status read has extra bits");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
        !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late or early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not offered one cycle after address");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");

    c_dir_load: cover property (s_axi_bvalid ##1 $changed(port_b_direction));
    c_dir_read: cover property (s_axi_rvalid && rd_dir);
    c_write: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
endmodule : mas_alu_properties

bind mas_alu_top mas_alu_properties u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
    .port_c_direction(port_c_direction)
);

//--- testbench/tb_top.sv
// self-checking bench for the alu subset top through its register bus
// assumes mas_regs.svh on the include path and the checker bound to the top
`timescale 1ns/1ps
`include "mas_regs.svh"

module tb_top
    import mas_pkg::*;
;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'h0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'h0;
    mas_byte_t port_a_direction;
    mas_byte_t port_b_direction;
    mas_byte_t port_c_direction;
    int n_errors = 0;
    int cmp_count = 0;
    mas_byte_t exp_dir [0:2] = '{8'hFF, 8'hFF, 8'hFF};
    mas_byte_t exp_res = 8'h00;
    logic [31:0] rv;

    always #20 aclk = ~aclk;

    mas_alu_top DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_a_direction(port_a_direction),
        .port_b_direction(port_b_direction), .port_c_direction(port_c_direction)
    );

    task automatic give_verdict;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 200) begin
            n_errors++;
            give_verdict();
        end
    endtask : tick

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = `MAS_RESP_OKAY);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            tick(n);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er = `MAS_RESP_OKAY,
                            input int lag = 0);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= (lag == 0);
        do begin
            tick(n);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (n >= lag && !s_axi_rready) s_axi_rready <= 1'h1;
        end while (!(s_axi_rvalid && s_axi_rready));
        v = s_axi_rdata;
        s_axi_rready <= 1'h0;
        check({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : axi_read

    // preload file, accumulator and flags, run one instruction, compare accumulator, that file register, flags, result and directions
    task automatic op_case(input logic [2:0] op, input logic d, input logic [6:0] f, input mas_byte_t k,
                           input mas_byte_t w, input mas_byte_t fv, input logic [2:0] st);
        logic [8:0] s;
        logic [4:0] h;
        mas_byte_t r;
        mas_byte_t ea;
        mas_byte_t ef;
        logic [2:0] es;
        logic [11:0] fa;
        fa = {3'h1, f, 2'h0};
        ea = w;
        ef = fv;
        es = st;
        r = 8'h00;
        axi_write(fa, {24'h0, fv});
        axi_write(`MAS_OFF_ACC, {24'h0, w});
        axi_write(`MAS_OFF_STATUS, {29'h0, st});
        case (op)
            3'h1: begin
                s = {1'h0, fv} - {1'h0, w} - {8'h00, ~st[0]};
                h = {1'h0, fv[3:0]} - {1'h0, w[3:0]} - {4'h0, ~st[0]};
                r = s[7:0];
                es = {r == 8'h00, ~h[4], ~s[8]};
            end
            3'h2: r = {fv[3:0], fv[7:4]};
            3'h3: r = w ^ k;
            3'h4: r = w ^ fv;
            default: r = 8'h00;
        endcase
        if (op == 3'h3 || op == 3'h4) es[2] = (r == 8'h00);
        if (op == 3'h5 && f >= 7'h05 && f <= 7'h07) exp_dir[f - 7'h05] = w;
        if (op != 3'h5) exp_res = r;
        if (op != 3'h5 && op != 3'h3 && d) ef = r;
        if (op != 3'h5 && (op == 3'h3 || !d)) ea = r;
        axi_write(`MAS_OFF_INSTR, {8'h00, k, 5'h00, f, d, op});
        axi_read(`MAS_OFF_ACC, rv);
        check(rv, {24'h0, ea});
        axi_read(fa, rv);
        check(rv, {24'h0, ef});
        axi_read(`MAS_OFF_STATUS, rv);
        check(rv, {29'h0, es});
        axi_read(`MAS_OFF_RESULT, rv);
        check(rv, {24'h0, exp_res});
        check({24'h0, port_a_direction}, {24'h0, exp_dir[0]});
        check({24'h0, port_b_direction}, {24'h0, exp_dir[1]});
        check({24'h0, port_c_direction}, {24'h0, exp_dir[2]});
    endtask : op_case

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        axi_read(`MAS_OFF_STATUS, rv);
        check(rv, 32'h00000000);
        axi_write(12'h100, 32'h000000FF, `MAS_RESP_SLVERR);
        axi_read(12'h100, rv, `MAS_RESP_SLVERR);
        check(rv, 32'h00000000);
        op_case(3'h1, 1'h0, 7'h00, 8'h00, 8'h05, 8'h10, 3'h1);
        op_case(3'h1, 1'h1, 7'h7F, 8'h00, 8'h05, 8'h05, 3'h0);
        op_case(3'h1, 1'h0, 7'h03, 8'h00, 8'h00, 8'h00, 3'h1);
        op_case(3'h1, 1'h1, 7'h40, 8'h00, 8'h01, 8'h10, 3'h4);
        op_case(3'h2, 1'h0, 7'h09, 8'h00, 8'h33, 8'hA5, 3'h7);
        op_case(3'h2, 1'h1, 7'h7F, 8'h00, 8'h21, 8'h0F, 3'h2);
        op_case(3'h3, 1'h0, 7'h00, 8'h3C, 8'h3C, 8'h00, 3'h3);
        op_case(3'h3, 1'h1, 7'h22, 8'hFF, 8'h0F, 8'h5A, 3'h4);
        op_case(3'h4, 1'h1, 7'h14, 8'h00, 8'hAA, 8'hAA, 3'h0);
        op_case(3'h4, 1'h0, 7'h00, 8'h00, 8'h81, 8'h18, 3'h7);
        op_case(3'h5, 1'h0, 7'h05, 8'h00, 8'h11, 8'h00, 3'h5);
        op_case(3'h5, 1'h0, 7'h06, 8'h00, 8'h22, 8'h00, 3'h2);
        op_case(3'h5, 1'h0, 7'h07, 8'h00, 8'h33, 8'h00, 3'h7);
        op_case(3'h5, 1'h0, 7'h08, 8'h00, 8'h44, 8'h00, 3'h0);
        axi_write(`MAS_OFF_DIR_A, 32'h00000000);
        axi_read(`MAS_OFF_DIR_A, rv, `MAS_RESP_OKAY, 3);
        check(rv, {24'h0, exp_dir[0]});
        give_verdict();
    end
endmodule : tb_top
